/* File: pkg/dri_pkg.sv */
package dri_pkg;

  // Timing at the 40 MHz control clock
  localparam int unsigned CLK_PERIOD_PS    = 25000;
  localparam int unsigned RST_HOLD_CYC     = 40;
  localparam int unsigned T_LOCK_A_NS      = 10000;
  localparam int unsigned T_LOCK_B_NS      = 10000;
  localparam int unsigned T_INIT_SLAVE_US  = 100;
  localparam int unsigned T_INIT_MASTER_US = 1000;
  localparam int unsigned T_WAKEUP_US      = 1000;
  localparam int unsigned T_LP_REJECT_NS   = 20;

  localparam int unsigned LOCK_A_CYC      = (T_LOCK_A_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned LOCK_B_CYC      = (T_LOCK_B_NS * 1000) / CLK_PERIOD_PS;
  localparam int unsigned INIT_SLAVE_CYC  =
    (T_INIT_SLAVE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned INIT_MASTER_CYC =
    (T_INIT_MASTER_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned WAKEUP_CYC      =
    (T_WAKEUP_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned LP_REJECT_CYC   =
    (T_LP_REJECT_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  localparam int unsigned TW = 16;
  localparam logic [TW-1:0] LOCK_A_M1     = TW'(LOCK_A_CYC - 1);
  localparam logic [TW-1:0] LOCK_B_M1     = TW'(LOCK_B_CYC - 1);
  localparam logic [TW-1:0] INIT_SLAVE_M1 = TW'(INIT_SLAVE_CYC - 1);
  localparam logic [3:0]    FILT_M1       = 4'(LP_REJECT_CYC - 1);

  // Line states {dp, dn}
  localparam logic [1:0] LP00 = 2'h0;
  localparam logic [1:0] LP01 = 2'h1;
  localparam logic [1:0] LP10 = 2'h2;
  localparam logic [1:0] LP11 = 2'h3;

  // Escape commands, MSB sent first
  localparam logic [7:0] ESC_LPDT  = 8'hE1;
  localparam logic [7:0] ESC_ULPS  = 8'h1E;
  localparam logic [7:0] ESC_TRIG0 = 8'h62;
  localparam logic [7:0] ESC_TRIG1 = 8'h5D;
  localparam logic [7:0] ESC_TRIG2 = 8'h21;
  localparam logic [7:0] ESC_TRIG3 = 8'hA0;

  // Register map
  localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
  localparam logic [31:0] ADDR_CFG  = 32'h0000_0004;
  localparam logic [31:0] ADDR_STAT = 32'h0000_0008;
  localparam logic [31:0] ADDR_LINE = 32'h0000_000C;
  localparam logic [1:0]  IDX_CTRL  = 2'h0;
  localparam logic [1:0]  IDX_CFG   = 2'h1;
  localparam logic [1:0]  IDX_STAT  = 2'h2;
  localparam logic [1:0]  IDX_LINE  = 2'h3;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam int unsigned CTRL_EN   = 0;
  localparam int unsigned CTRL_SOFT_RESET_BIT = 1;
  localparam int unsigned CTRL_WAKE = 2;
  localparam logic        EN_RST    = 1'b1;
  localparam logic        WAKE_RST  = 1'b0;
  localparam logic [7:0]  LPX_RST   = 8'h02;

  typedef enum logic [2:0] {SQ_LOCKA, SQ_LOCKB, SQ_INIT, SQ_LPX, SQ_RUN} dri_seq_t;
  typedef enum logic [3:0] {LN_STOP, LN_HSRQ, LN_HSPRE, LN_HS, LN_ESC1, LN_ESC2, LN_ESC3,
                            LN_CMD, LN_LPDT, LN_IGN, LN_ULPS, LN_WAKE} dri_lane_t;

  typedef struct packed {
    logic        pend;
    logic        wr;
    logic        hit;
    logic [1:0]  idx;
    logic        ready;
    logic        resp;
    logic [31:0] rdata;
  } dri_bus_t;

  typedef struct packed {
    logic       enable;
    logic       wake_en;
    logic [7:0] lpx;
  } dri_regs_t;

  typedef struct packed {
    logic [1:0]    sync1;
    logic [1:0]    sync2;
    logic [1:0]    cand;
    logic [3:0]    fcnt;
    logic [1:0]    line;
    logic          line_new;
    dri_seq_t      seq;
    logic [TW-1:0] tcnt;
    logic          lock_a;
    logic          lock_b;
    logic          init_done;
  } dri_phy_t;

  typedef struct packed {
    dri_lane_t     lane;
    logic [TW-1:0] tcnt;
    logic [7:0]    sh;
    logic [2:0]    bcnt;
    logic          stopstate;
    logic          hs_active;
    logic          hs_ready;
    logic          lp_oe;
    logic [1:0]    lp_out;
    logic [7:0]    esc_data;
    logic          esc_valid;
    logic [3:0]    trig;
    logic          ulps;
  } dri_pcs_t;

  typedef struct packed {
    dri_bus_t  bus;
    dri_regs_t regs;
    dri_phy_t  phy;
    dri_pcs_t  pcs;
  } dri_state_t;

  typedef struct packed {
    logic [24:0] zero;
    logic        is_tx;
    logic        ulps;
    logic        hs_active;
    logic        stopstate;
    logic        init_done;
    logic        lock_b;
    logic        lock_a;
  } dri_stat_t;

  localparam dri_bus_t BUS_RST = '{pend: 1'b0, wr: 1'b0, hit: 1'b0, idx: 2'h0, ready: 1'b1,
                                   resp: 1'b0, rdata: 32'h0000_0000};
  localparam dri_regs_t REGS_RST = '{enable: EN_RST, wake_en: WAKE_RST, lpx: LPX_RST};
  localparam dri_phy_t PHY_RST = '{sync1: LP00, sync2: LP00, cand: LP00, fcnt: 4'h0,
                                   line: LP00, line_new: 1'b0, seq: SQ_LOCKA,
                                   tcnt: 16'h0000, lock_a: 1'b0, lock_b: 1'b0,
                                   init_done: 1'b0};
  localparam dri_pcs_t PCS_RST = '{lane: LN_STOP, tcnt: 16'h0000, sh: 8'h00, bcnt: 3'h0,
                                   stopstate: 1'b0, hs_active: 1'b0, hs_ready: 1'b0,
                                   lp_oe: 1'b0, lp_out: LP11, esc_data: 8'h00,
                                   esc_valid: 1'b0, trig: 4'h0, ulps: 1'b0};

endpackage : dri_pkg

/* File: hw/dri_core.sv */
// Behaviour
// - Both lock indications low during reset
// - First lock within 100 us of release
// - Second lock within 100 us of first
// - Transmitter holds LP-11 for init time
// - Idle output after one LP unit period
// - Each reset source clears its own parts
// - Enable bit cleared equals core reset
// - Receiver idle 100 us after release
// - Transmitter idle 1 ms after release
// - Byte data accepted only once idle
// - Line states under 20 ns ignored
// - Bursts start and end in LP-11
// - Receiver init needs LP-11 over 100 us
// - Four escape triggers, each flagged upward
// - Escape decoding self-clocked, spaced-one-hot
// - Data after a trigger is ignored
// - Low-power data 10 Mb/s, 20 MHz max
// - Wake counter: LP-10 1 ms then stop
// - No wake counter: exit on LP-10
`timescale 1ns/10ps
module dri_core #(
  parameter bit          IS_TX       = 1'b1,
  parameter int unsigned INIT_TX_CYC = dri_pkg::INIT_MASTER_CYC,
  parameter int unsigned WAKEUP_CYC  = dri_pkg::WAKEUP_CYC
) (
  input  wire logic        clk_i,        // 40 MHz control clock
  input  wire logic        arst_n_i,     // Core reset, active low
  input  wire logic        hresetn_i,    // Bus reset, registers only
  input  wire logic        hsel_i,       // AHB select
  input  wire logic [31:0] haddr_i,      // AHB address
  input  wire logic [1:0]  htrans_i,     // AHB transfer type
  input  wire logic        hwrite_i,     // AHB write
  input  wire logic [2:0]  hsize_i,      // AHB size
  input  wire logic        hready_i,     // AHB bus ready
  input  wire logic [31:0] hwdata_i,     // AHB write data
  output logic             hreadyout_o,  // AHB slave ready
  output logic             hresp_o,      // AHB response, always OKAY
  output logic [31:0]      hrdata_o,     // AHB read data
  input  wire logic        hs_req_i,     // Burst request, transmitter
  input  wire logic        lp_dp_i,      // Lane wire in, positive
  input  wire logic        lp_dn_i,      // Lane wire in, negative
  output logic             lp_dp_o,      // Lane wire out, positive
  output logic             lp_dn_o,      // Lane wire out, negative
  output logic             lp_oe_o,      // LP drivers enabled
  output logic             lock_a_o,     // First clock generator locked
  output logic             lock_b_o,     // Second clock generator locked
  output logic             init_done_o,  // Lane initialisation complete
  output logic             stopstate_o,  // Lane idle in stop state
  output logic             hs_ready_o,   // Burst data accepted (transmitter)
  output logic             hs_active_o,  // High-speed burst in progress
  output logic [7:0]       esc_data_o,   // Low-power data byte (receiver)
  output logic             esc_valid_o,  // Low-power byte strobe
  output logic [3:0]       trig_o,       // Trigger strobes, one per kind
  output logic             ulps_active_o // Lane in ultra-low-power state
);

  localparam logic [15:0] INIT_TX_M1 = 16'(INIT_TX_CYC - 1);
  localparam logic [15:0] WAKE_M1    = 16'(WAKEUP_CYC - 1);
  localparam logic [15:0] INIT_M1    = IS_TX ? INIT_TX_M1 : dri_pkg::INIT_SLAVE_M1;

  dri_pkg::dri_state_t q;
  dri_pkg::dri_state_t d;

  function automatic logic is_mark(input logic [1:0] ln);
    is_mark = (ln == dri_pkg::LP10) || (ln == dri_pkg::LP01);
  endfunction : is_mark

  function automatic logic [3:0] trig_of(input logic [7:0] cmd);
    unique case (cmd)
      dri_pkg::ESC_TRIG0: trig_of = 4'h1;
      dri_pkg::ESC_TRIG1: trig_of = 4'h2;
      dri_pkg::ESC_TRIG2: trig_of = 4'h4;
      dri_pkg::ESC_TRIG3: trig_of = 4'h8;
      default:            trig_of = 4'h0;
    endcase
  endfunction : trig_of

  function automatic logic [2:0] addr_dec(input logic [31:0] a);
    unique case (a)
      dri_pkg::ADDR_CTRL: addr_dec = {1'b1, dri_pkg::IDX_CTRL};
      dri_pkg::ADDR_CFG:  addr_dec = {1'b1, dri_pkg::IDX_CFG};
      dri_pkg::ADDR_STAT: addr_dec = {1'b1, dri_pkg::IDX_STAT};
      dri_pkg::ADDR_LINE: addr_dec = {1'b1, dri_pkg::IDX_LINE};
      default:            addr_dec = 3'h0;
    endcase
  endfunction : addr_dec

  function automatic logic [31:0] rd_word(input dri_pkg::dri_state_t s);
    dri_pkg::dri_stat_t st;
    st = '{zero: 25'h0, is_tx: IS_TX, ulps: s.pcs.ulps, hs_active: s.pcs.hs_active,
           stopstate: s.pcs.stopstate, init_done: s.phy.init_done,
           lock_b: s.phy.lock_b, lock_a: s.phy.lock_a};
    rd_word = 32'h0000_0000;
    if (s.bus.hit) begin
      unique case (s.bus.idx)
        dri_pkg::IDX_CTRL: begin
          rd_word[dri_pkg::CTRL_EN]   = s.regs.enable;
          rd_word[dri_pkg::CTRL_WAKE] = s.regs.wake_en;
        end
        dri_pkg::IDX_CFG:  rd_word = {24'h00_0000, s.regs.lpx};
        dri_pkg::IDX_STAT: rd_word = st;
        dri_pkg::IDX_LINE: rd_word = {30'h0000_0000, s.phy.line};
      endcase
    end
  endfunction : rd_word

  always_comb begin
    logic soft_rst;
    logic [1:0] ln;
    logic [7:0] sh_nx;
    soft_rst = 1'b0;
    ln       = q.phy.line;
    sh_nx    = {q.pcs.sh[6:0], q.phy.line[1]};
    d        = q;
    d.pcs.esc_valid = 1'b0;
    d.pcs.trig      = 4'h0;
    d.bus.resp      = 1'b0;

    // Two-flop synchroniser; only stage two is read
    d.phy.sync1    = {lp_dp_i, lp_dn_i};
    d.phy.sync2    = q.phy.sync1;
    d.phy.line_new = 1'b0;
    // Two samples needed, so a sub-20 ns pulse is dropped
    if (q.phy.sync2 != q.phy.cand) begin
      d.phy.cand = q.phy.sync2;
      d.phy.fcnt = 4'h0;
    end else if (q.phy.cand != q.phy.line) begin
      if (q.phy.fcnt >= dri_pkg::FILT_M1) begin
        d.phy.line     = q.phy.cand;
        d.phy.line_new = 1'b1;
      end else begin
        d.phy.fcnt = q.phy.fcnt + 4'h1;
      end
    end

    // Power-up: locks, line init, one LP unit of stop
    unique case (q.phy.seq)
      dri_pkg::SQ_LOCKA: begin
        if (q.phy.tcnt >= dri_pkg::LOCK_A_M1) begin
          d.phy.lock_a = 1'b1;
          d.phy.tcnt   = 16'h0000;
          d.phy.seq    = dri_pkg::SQ_LOCKB;
        end else begin
          d.phy.tcnt = q.phy.tcnt + 16'h0001;
        end
      end
      dri_pkg::SQ_LOCKB: begin
        if (q.phy.tcnt >= dri_pkg::LOCK_B_M1) begin
          d.phy.lock_b = 1'b1;
          d.phy.tcnt   = 16'h0000;
          d.phy.seq    = dri_pkg::SQ_INIT;
        end else begin
          d.phy.tcnt = q.phy.tcnt + 16'h0001;
        end
      end
      dri_pkg::SQ_INIT: begin
        if (!IS_TX && q.phy.line != dri_pkg::LP11) begin
          d.phy.tcnt = 16'h0000;
        end else if (q.phy.tcnt >= INIT_M1) begin
          d.phy.init_done = 1'b1;
          d.phy.tcnt      = 16'h0000;
          d.phy.seq       = dri_pkg::SQ_LPX;
        end else begin
          d.phy.tcnt = q.phy.tcnt + 16'h0001;
        end
      end
      dri_pkg::SQ_LPX: begin
        if (!IS_TX && q.phy.line != dri_pkg::LP11) begin
          d.phy.tcnt = 16'h0000;
        end else if ((q.phy.tcnt + 16'h0001) >= {8'h00, q.regs.lpx}) begin
          d.phy.seq = dri_pkg::SQ_RUN;
        end else begin
          d.phy.tcnt = q.phy.tcnt + 16'h0001;
        end
      end
      dri_pkg::SQ_RUN: begin
      end
    endcase

    // Lane held at stop, not idle, until SQ_RUN, one LP unit after init ends
    if (q.phy.seq != dri_pkg::SQ_RUN) begin
      d.pcs.lane      = dri_pkg::LN_STOP;
      d.pcs.stopstate = 1'b0;
      d.pcs.lp_out    = dri_pkg::LP11;
      d.pcs.lp_oe     = IS_TX && q.phy.lock_b;
    end else if (IS_TX) begin
      unique case (q.pcs.lane)
        dri_pkg::LN_STOP: begin
          d.pcs.lp_out    = dri_pkg::LP11;
          d.pcs.stopstate = 1'b1;
          if (hs_req_i && q.pcs.stopstate) begin
            d.pcs.lane      = dri_pkg::LN_HSRQ;
            d.pcs.lp_out    = dri_pkg::LP01;
            d.pcs.stopstate = 1'b0;
            d.pcs.tcnt      = 16'h0000;
          end
        end
        dri_pkg::LN_HSRQ: begin
          if ((q.pcs.tcnt + 16'h0001) >= {8'h00, q.regs.lpx}) begin
            d.pcs.lane   = dri_pkg::LN_HSPRE;
            d.pcs.lp_out = dri_pkg::LP00;
            d.pcs.tcnt   = 16'h0000;
          end else begin
            d.pcs.tcnt = q.pcs.tcnt + 16'h0001;
          end
        end
        dri_pkg::LN_HSPRE: begin
          if ((q.pcs.tcnt + 16'h0001) >= {8'h00, q.regs.lpx}) begin
            d.pcs.lane      = dri_pkg::LN_HS;
            d.pcs.lp_oe     = 1'b0;
            d.pcs.hs_active = 1'b1;
            d.pcs.hs_ready  = 1'b1;
          end else begin
            d.pcs.tcnt = q.pcs.tcnt + 16'h0001;
          end
        end
        dri_pkg::LN_HS: begin
          if (!hs_req_i) begin
            d.pcs.lane      = dri_pkg::LN_STOP;
            d.pcs.lp_oe     = 1'b1;
            d.pcs.lp_out    = dri_pkg::LP11;
            d.pcs.hs_active = 1'b0;
            d.pcs.hs_ready  = 1'b0;
          end
        end
        default: d.pcs.lane = dri_pkg::LN_STOP;
      endcase
    end else begin
      // Receiver escape path needs no lane clock
      unique case (q.pcs.lane)
        dri_pkg::LN_STOP: begin
          d.pcs.stopstate = 1'b1;
          if (ln == dri_pkg::LP01) begin
            d.pcs.lane      = dri_pkg::LN_HSRQ;
            d.pcs.stopstate = 1'b0;
          end else if (ln == dri_pkg::LP10) begin
            d.pcs.lane      = dri_pkg::LN_ESC1;
            d.pcs.stopstate = 1'b0;
          end
        end
        dri_pkg::LN_HSRQ: begin
          if (ln == dri_pkg::LP00) begin
            d.pcs.lane      = dri_pkg::LN_HS;
            d.pcs.hs_active = 1'b1;
          end else if (ln == dri_pkg::LP11) begin
            d.pcs.lane = dri_pkg::LN_STOP;
          end else if (ln == dri_pkg::LP10) begin
            d.pcs.lane = dri_pkg::LN_IGN;
          end
        end
        dri_pkg::LN_HS: begin
          if (ln == dri_pkg::LP11) begin
            d.pcs.lane      = dri_pkg::LN_STOP;
            d.pcs.hs_active = 1'b0;
          end
        end
        dri_pkg::LN_ESC1, dri_pkg::LN_ESC2, dri_pkg::LN_ESC3: begin
          if (ln == dri_pkg::LP11) begin
            d.pcs.lane = dri_pkg::LN_STOP;
          end else if (q.pcs.lane == dri_pkg::LN_ESC1 && ln == dri_pkg::LP00) begin
            d.pcs.lane = dri_pkg::LN_ESC2;
          end else if (q.pcs.lane == dri_pkg::LN_ESC2 && ln == dri_pkg::LP01) begin
            d.pcs.lane = dri_pkg::LN_ESC3;
          end else if (q.pcs.lane == dri_pkg::LN_ESC3 && ln == dri_pkg::LP00) begin
            d.pcs.lane = dri_pkg::LN_CMD;
            d.pcs.bcnt = 3'h0;
          end else if (q.phy.line_new && ln != dri_pkg::LP00) begin
            d.pcs.lane = dri_pkg::LN_IGN;
          end
        end
        dri_pkg::LN_CMD, dri_pkg::LN_LPDT: begin
          if (ln == dri_pkg::LP11) begin
            d.pcs.lane = dri_pkg::LN_STOP;
          end else if (q.phy.line_new && is_mark(ln)) begin
            d.pcs.sh   = sh_nx;
            d.pcs.bcnt = q.pcs.bcnt + 3'h1;
            if (q.pcs.bcnt == 3'h7) begin
              if (q.pcs.lane == dri_pkg::LN_LPDT) begin
                d.pcs.esc_data  = sh_nx;
                d.pcs.esc_valid = 1'b1;
              end else if (sh_nx == dri_pkg::ESC_LPDT) begin
                d.pcs.lane = dri_pkg::LN_LPDT;
              end else if (sh_nx == dri_pkg::ESC_ULPS) begin
                d.pcs.lane = dri_pkg::LN_ULPS;
                d.pcs.ulps = 1'b1;
              end else begin
                d.pcs.trig = trig_of(sh_nx);
                d.pcs.lane = dri_pkg::LN_IGN;
              end
            end
          end
        end
        dri_pkg::LN_IGN: begin
          if (ln == dri_pkg::LP11) begin
            d.pcs.lane = dri_pkg::LN_STOP;
          end
        end
        dri_pkg::LN_ULPS: begin
          if (ln == dri_pkg::LP10) begin
            d.pcs.tcnt = 16'h0000;
            if (q.regs.wake_en) begin
              d.pcs.lane = dri_pkg::LN_WAKE;
            end else begin
              d.pcs.ulps = 1'b0;
              d.pcs.lane = dri_pkg::LN_IGN;
            end
          end
        end
        dri_pkg::LN_WAKE: begin
          if (ln == dri_pkg::LP10) begin
            if (q.pcs.tcnt != 16'hFFFF) begin
              d.pcs.tcnt = q.pcs.tcnt + 16'h0001;
            end
          end else if (ln == dri_pkg::LP11 && q.pcs.tcnt >= WAKE_M1) begin
            d.pcs.ulps = 1'b0;
            d.pcs.lane = dri_pkg::LN_STOP;
          end else begin
            d.pcs.lane = dri_pkg::LN_ULPS;
          end
        end
        default: d.pcs.lane = dri_pkg::LN_STOP;
      endcase
    end

    // One wait state keeps reads and writes fresh
    if (q.bus.pend) begin
      d.bus.pend  = 1'b0;
      d.bus.ready = 1'b1;
      if (!q.bus.wr) begin
        d.bus.rdata = rd_word(q);
      end else if (q.bus.hit && q.bus.idx == dri_pkg::IDX_CTRL) begin
        d.regs.enable  = hwdata_i[dri_pkg::CTRL_EN];
        d.regs.wake_en = hwdata_i[dri_pkg::CTRL_WAKE];
        soft_rst       = hwdata_i[dri_pkg::CTRL_SOFT_RESET_BIT];
      end else if (q.bus.hit && q.bus.idx == dri_pkg::IDX_CFG) begin
        d.regs.lpx = hwdata_i[7:0];
      end
    end else if (hsel_i && htrans_i[1] && hready_i) begin
      d.bus.pend = 1'b1;
      d.bus.ready = 1'b0;
      d.bus.wr = hwrite_i;
      {d.bus.hit, d.bus.idx} = (hsize_i == dri_pkg::HSIZE_WORD) ? addr_dec(haddr_i) : 3'h0;
    end

    // Partial resets; enable clear acts as core reset
    if (!q.regs.enable) begin
      d.phy          = dri_pkg::PHY_RST;
      d.pcs          = dri_pkg::PCS_RST;
      d.regs.wake_en = dri_pkg::WAKE_RST;
      d.regs.lpx     = dri_pkg::LPX_RST;
    end
    if (soft_rst) begin
      d.pcs          = dri_pkg::PCS_RST;
      d.regs.wake_en = dri_pkg::WAKE_RST;
      d.regs.lpx     = dri_pkg::LPX_RST;
    end
    if (!hresetn_i) begin
      d.regs = dri_pkg::REGS_RST;
      d.bus  = dri_pkg::BUS_RST;
    end
  end

  // One edge of reset reaches every flop
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      q <= '{bus: dri_pkg::BUS_RST, regs: dri_pkg::REGS_RST,
             phy: dri_pkg::PHY_RST, pcs: dri_pkg::PCS_RST};
    end else begin
      q <= d;
    end
  end

  assign hreadyout_o   = q.bus.ready;
  assign hresp_o       = q.bus.resp;
  assign hrdata_o      = q.bus.rdata;
  assign lp_dp_o       = q.pcs.lp_out[1];
  assign lp_dn_o       = q.pcs.lp_out[0];
  assign lp_oe_o       = q.pcs.lp_oe;
  assign lock_a_o      = q.phy.lock_a;
  assign lock_b_o      = q.phy.lock_b;
  assign init_done_o   = q.phy.init_done;
  assign stopstate_o   = q.pcs.stopstate;
  assign hs_ready_o    = q.pcs.hs_ready;
  assign hs_active_o   = q.pcs.hs_active;
  assign esc_data_o    = q.pcs.esc_data;
  assign esc_valid_o   = q.pcs.esc_valid;
  assign trig_o        = q.pcs.trig;
  assign ulps_active_o = q.pcs.ulps;

endmodule : dri_core

/* File: dv/dri_core_sva.sv */
`timescale 1ns/10ps
module dri_core_sva (
  input wire logic       clk_i,       // Control clock
  input wire logic       arst_n_i,    // Core reset
  input wire logic       hsel_i,      // Bus select
  input wire logic [1:0] htrans_i,    // Bus transfer type
  input wire logic       hready_i,    // Bus ready
  input wire logic       hreadyout_o, // Slave ready
  input wire logic       lp_dp_i,     // Lane wire
  input wire logic       lp_dn_i,     // Lane wire
  input wire logic       lock_a_o,    // First lock
  input wire logic       lock_b_o,    // Second lock
  input wire logic       init_done_o, // Init complete
  input wire logic       stopstate_o, // Lane idle
  input wire logic       hs_active_o, // Burst active
  input wire logic [3:0] trig_o       // Trigger strobes
);
  localparam int INIT_RX = 4000;
  int lp11_q, wa_q, wb_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  // Raw pin count, a lower bound; lock waits counted in cycles
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lp11_q <= 0;
      wa_q   <= 0;
      wb_q   <= 0;
    end else begin
      lp11_q <= ({lp_dp_i, lp_dn_i} == 2'h3) ? lp11_q + 1 : 0;
      wa_q   <= lock_a_o ? 0 : wa_q + 1;
      wb_q   <= (lock_a_o && !lock_b_o) ? wb_q + 1 : 0;
    end
  end
  sequence s_quiet;
    trig_o == 4'h0;
  endsequence
  a_lock_rst_low: assert property ($rose(arst_n_i) |-> !lock_a_o && !lock_b_o)
    else $error("lock in reset");
  a_lock_a_time: assert property (wa_q < INIT_RX)
    else $error("first lock late");
  a_lock_b_time: assert property (wb_q < INIT_RX)
    else $error("second lock late");
  a_init_line: assert property ($rose(init_done_o) |-> lp11_q > INIT_RX)
    else $error("init too early");
  a_idle_after: assert property ($rose(init_done_o) |-> ##[1:8] stopstate_o)
    else $error("no idle");
  a_idle_needs: assert property (stopstate_o |-> init_done_o && lock_b_o)
    else $error("idle before init");
  a_trig_pulse: assert property (trig_o != 4'h0 |-> $onehot(trig_o) ##1 s_quiet)
    else $error("bad trigger");
  a_burst_end: assert property ($fell(hs_active_o) |-> ##[0:2] stopstate_o)
    else $error("burst end");
  a_bus_wait: assert property (hsel_i && htrans_i[1] && hready_i && hreadyout_o
                               |=> !hreadyout_o ##1 hreadyout_o)
    else $error("bad wait");
endmodule : dri_core_sva
bind dri_core dri_core_sva i_dri_core_sva (.*);

/* File: dv/dri_lane_drv.sv */
`timescale 1ns/10ps
module dri_lane_drv (
  input  wire logic clk_i,   // Paces link periods
  output logic      lp_dp_o, // Lane positive wire
  output logic      lp_dn_o  // Lane negative wire
);
  initial {lp_dp_o, lp_dn_o} = dri_pkg::LP11;
  // Holds state s for n link periods of 200 ns each
  task automatic put(input logic [1:0] s, input int n);
    {lp_dp_o, lp_dn_o} <= s;
    repeat (8 * n) @(posedge clk_i);
  endtask : put
  task automatic esc(input logic [7:0] c, input logic [7:0] d, input int nb);
    logic [15:0] w;
    w = {c, d};
    put(dri_pkg::LP10, 1);
    put(dri_pkg::LP00, 1);
    put(dri_pkg::LP01, 1);
    put(dri_pkg::LP00, 1);
    for (int i = 15; i >= 16 - nb; i--) begin
      put(w[i] ? dri_pkg::LP10 : dri_pkg::LP01, 1);
      put(dri_pkg::LP00, 1);
    end
  endtask : esc
  // Under 20 ns, straddles an edge
  task automatic glitch();
    #20 {lp_dp_o, lp_dn_o} = dri_pkg::LP00;
    #15 {lp_dp_o, lp_dn_o} = dri_pkg::LP11;
  endtask : glitch
endmodule : dri_lane_drv

/* File: dv/dri_core_tb.sv */
`timescale 1ns/10ps
module dri_core_tb;
  logic        clk_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic        hresetn_i = 1'b1;
  logic        hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0000_0000;
  logic [1:0]  htrans_i = 2'h0;
  logic        hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic        hreadyout_o, lane_dp, lane_dn, lock_a_o, lock_b_o, init_done_o;
  logic        stopstate_o, hs_active_o, esc_valid_o, ulps_active_o;
  logic [31:0] hrdata_o;
  logic [7:0]  esc_data_o, ebyte;
  logic [3:0]  trig_o;
  int          num_errors = 0, total_checks = 0, cyc = 0, nval = 0;
  int          tcnt [4] = '{default: 0};
  always #12.5 clk_i = ~clk_i;
  dri_core #(.IS_TX(1'b0), .INIT_TX_CYC(200), .WAKEUP_CYC(100)) i_dri_core (.clk_i, .arst_n_i,
    .hresetn_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(dri_pkg::HSIZE_WORD),
    .hready_i(hreadyout_o), .hwdata_i, .hreadyout_o, .hresp_o(), .hrdata_o, .hs_req_i(1'b0),
    .lp_dp_i(lane_dp), .lp_dn_i(lane_dn), .lp_dp_o(), .lp_dn_o(), .lp_oe_o(), .lock_a_o,
    .lock_b_o, .init_done_o, .stopstate_o, .hs_ready_o(), .hs_active_o, .esc_data_o,
    .esc_valid_o, .trig_o, .ulps_active_o);
  dri_lane_drv i_dri_lane_drv (.clk_i, .lp_dp_o(lane_dp), .lp_dn_o(lane_dn));
  always @(posedge clk_i) begin
    cyc++;
    if (esc_valid_o === 1'b1) begin
      nval++;
      ebyte = esc_data_o;
    end
    for (int k = 0; k < 4; k++)
      if (trig_o[k] === 1'b1) tcnt[k]++;
    if (cyc == 40000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= a;
    hwrite_i <= w;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
    r = hrdata_o;
  endtask : ahb
  task automatic t_init();
    int n;
    logic [31:0] rd;
    n = 0;
    while (stopstate_o !== 1'b1) begin
      n++;
      @(posedge clk_i);
    end
    chk(n > 4000, 1'b1);
    chk(n < 12000, 1'b1);
    ahb(1'b0, dri_pkg::ADDR_STAT, 32'h0, rd);
    chk(rd, 32'h0000_000F);
  endtask : t_init
  task automatic t_regs();
    logic [31:0] rd;
    ahb(1'b1, dri_pkg::ADDR_CFG, 32'h0000_0005, rd);
    ahb(1'b0, 32'h0000_0010, 32'h0, rd);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, dri_pkg::ADDR_CTRL, 32'h0000_0003, rd);
    ahb(1'b0, dri_pkg::ADDR_CFG, 32'h0, rd);
    chk(rd, 32'h0000_0002);
    chk(init_done_o, 1'b1);
    ahb(1'b1, dri_pkg::ADDR_CFG, 32'h0000_0005, rd);
    hresetn_i <= 1'b0;
    @(posedge clk_i);
    hresetn_i <= 1'b1;
    ahb(1'b0, dri_pkg::ADDR_CFG, 32'h0, rd);
    chk(rd, 32'h0000_0002);
    chk(stopstate_o, 1'b1);
  endtask : t_regs
  task automatic t_hs();
    i_dri_lane_drv.glitch();
    repeat (12) @(posedge clk_i);
    chk({stopstate_o, hs_active_o}, 2'h2);
    i_dri_lane_drv.put(dri_pkg::LP01, 1);
    i_dri_lane_drv.put(dri_pkg::LP00, 2);
    chk({stopstate_o, hs_active_o}, 2'h1);
    i_dri_lane_drv.put(dri_pkg::LP11, 2);
    chk({stopstate_o, hs_active_o}, 2'h2);
  endtask : t_hs
  task automatic t_trig();
    logic [7:0] cd [4] = '{dri_pkg::ESC_TRIG0, dri_pkg::ESC_TRIG1, dri_pkg::ESC_TRIG2,
                           dri_pkg::ESC_TRIG3};
    for (int k = 0; k < 4; k++) begin
      int t0, s0, v0;
      t0 = tcnt[k];
      s0 = tcnt.sum();
      v0 = nval;
      // Trailing LPDT code must be ignored
      i_dri_lane_drv.esc(cd[k], dri_pkg::ESC_LPDT, 16);
      i_dri_lane_drv.put(dri_pkg::LP11, 2);
      chk(tcnt[k] - t0, 1);
      chk(tcnt.sum() - s0, 1);
      chk(nval - v0, 0);
    end
  endtask : t_trig
  task automatic t_lpdt();
    int v0;
    v0 = nval;
    i_dri_lane_drv.esc(dri_pkg::ESC_LPDT, 8'hA5, 16);
    i_dri_lane_drv.put(dri_pkg::LP11, 2);
    chk(nval - v0, 1);
    chk(ebyte, 8'hA5);
  endtask : t_lpdt
  task automatic t_ulps();
    logic [31:0] rd;
    for (int w = 0; w < 2; w++) begin
      ahb(1'b1, dri_pkg::ADDR_CTRL, {29'h0, w[0], 2'h1}, rd);
      i_dri_lane_drv.esc(dri_pkg::ESC_ULPS, 8'h00, 8);
      i_dri_lane_drv.put(dri_pkg::LP00, 2);
      chk(ulps_active_o, 1'b1);
      i_dri_lane_drv.put(dri_pkg::LP10, 1 + 14 * w);
      chk(ulps_active_o, w[0]);
      i_dri_lane_drv.put(dri_pkg::LP11, 2);
      chk({stopstate_o, ulps_active_o}, 2'h2);
    end
  endtask : t_ulps
  task automatic t_en();
    logic [31:0] rd;
    ahb(1'b1, dri_pkg::ADDR_CTRL, 32'h0000_0000, rd);
    repeat (2) @(posedge clk_i);
    chk({lock_a_o, lock_b_o, init_done_o, stopstate_o}, 4'h0);
    ahb(1'b1, dri_pkg::ADDR_CTRL, 32'h0000_0001, rd);
    t_init();
  endtask : t_en
  task automatic summarize();
    $display("Checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : summarize
  initial begin
    repeat (40) @(posedge clk_i);
    arst_n_i <= 1'b1;
    t_init();
    t_regs();
    t_hs();
    t_trig();
    t_lpdt();
    t_ulps();
    t_en();
    summarize();
  end
endmodule : dri_core_tb
